// *** verilog/test_pattern_pkg.sv ***
// Purpose: Shared constants for the output test pattern generator.
// Assumes: Registers are reached over an 8-bit address/data read/write port.
// Notes: Pattern words are 16 bits and cut to the bus width by keeping the MSB end.
package test_pattern_pkg;
  localparam logic [7:0] ADDR_TEST_CTRL = 8'hc0;
  localparam logic [7:0] ADDR_USER1_LOW = 8'hc2;
  localparam logic [7:0] ADDR_USER1_HIGH = 8'hc3;
  localparam logic [7:0] ADDR_USER2_LOW = 8'hc4;
  localparam logic [7:0] ADDR_USER2_HIGH = 8'hc5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int MODE_LSB = 6;
  localparam int MODE_MSB = 7;
  localparam int PATT_LSB = 0;
  localparam int PATT_MSB = 3;
  localparam logic [1:0] MODE_STATIC = 2'h0;
  localparam logic [1:0] MODE_ALTERNATE = 2'h1;
  localparam logic [3:0] PATT_OFF = 4'h0;
  localparam logic [3:0] PATT_MIDSCALE = 4'h1;
  localparam logic [3:0] PATT_POS_FULL = 4'h2;
  localparam logic [3:0] PATT_NEG_FULL = 4'h3;
  localparam logic [3:0] PATT_CHECKER = 4'h4;
  localparam logic [3:0] PATT_ONE_ZERO = 4'h7;
  localparam logic [3:0] PATT_USER = 4'h8;
  localparam logic [15:0] WORD_MIDSCALE = 16'h8000;
  localparam logic [15:0] WORD_ONES = 16'hffff;
  localparam logic [15:0] WORD_ZEROS = 16'h0000;
  localparam logic [15:0] WORD_CHECK_A = 16'haaaa;
  localparam logic [15:0] WORD_CHECK_B = 16'h5555;
  localparam int FIFO_DEPTH = 16;
endpackage

// *** verilog/sample_stream_if.sv ***
// Purpose: Valid/ready sample stream between generator and output FIFO.
// Assumes: One clock domain.
// Notes: Source drives valid and data; sink drives ready.
`timescale 1ns/100ps
interface sample_stream_if #(parameter int WIDTH = 12);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// *** verilog/sample_fifo.sv ***
// Purpose: Synchronous FIFO buffering output samples.
// Assumes: Depth is a power of two.
// Notes: Full and empty are exact; ready on the fill side is not full.
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  sample_stream_if.sink in_s,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sample_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full;
  logic push;
  logic pop;

  // Pointer compare gives honest full and empty
  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
    (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign in_s.ready = !full;
  assign push = in_s.valid && !full;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r[AW-1:0]];

  // Storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_s.data;
    end
  end

  // Pointer update
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule // sample_fifo

// *** verilog/output_test_pattern_generator.sv ***
// Purpose: Replace converter samples on the output bus with test words.
// Assumes: Register writes and reads use a simple synchronous byte port.
// Notes: Output data leaves through a FIFO that the capture side can stall.
// Notes: Control changes act on the next accepted sample, unsynchronised.
`timescale 1ns/100ps
module output_test_pattern_generator #(
  parameter int WIDTH = 12
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [WIDTH-1:0] sample_data,
  output logic sample_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic pattern_active
);
  // Pattern words are 16 bits, so a wider bus cannot be filled
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("output bus width must be 1 to 16");
  end

  // Register copies and read data
  logic [7:0] test_pattern_control_r;
  logic [7:0] user_word1_low_r;
  logic [7:0] user_word1_high_r;
  logic [7:0] user_word2_low_r;
  logic [7:0] user_word2_high_r;
  logic [7:0] reg_rdata_r;
  logic phase_r;

  // Decoded control fields and assembled user words
  logic [1:0] test_mode;
  logic [3:0] patt_code;
  logic [15:0] first_user_word;
  logic [15:0] second_user_word;

  // Pattern table results
  logic [15:0] word1;
  logic [15:0] word2;
  logic has_word2;
  logic patt_on;

  // Word selection and the stream into the buffer
  logic alt_mode;
  logic [15:0] sel_word;
  logic [WIDTH-1:0] gen_data;
  logic gen_valid;

  // Stream from the word selector into the output buffer
  sample_stream_if #(.WIDTH(WIDTH)) gen_s ();

  // Control field decode and user word assembly
  assign test_mode = test_pattern_control_r[
    test_pattern_pkg::MODE_MSB:test_pattern_pkg::MODE_LSB];
  assign patt_code = test_pattern_control_r[
    test_pattern_pkg::PATT_MSB:test_pattern_pkg::PATT_LSB];
  assign first_user_word = {user_word1_high_r, user_word1_low_r};
  assign second_user_word = {user_word2_high_r, user_word2_low_r};

  // Register writes, applied immediately, without waiting for a sample
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      test_pattern_control_r <= test_pattern_pkg::RESET_BYTE;
      user_word1_low_r <= test_pattern_pkg::RESET_BYTE;
      user_word1_high_r <= test_pattern_pkg::RESET_BYTE;
      user_word2_low_r <= test_pattern_pkg::RESET_BYTE;
      user_word2_high_r <= test_pattern_pkg::RESET_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        test_pattern_pkg::ADDR_TEST_CTRL: begin
          test_pattern_control_r <= reg_wdata;
        end
        test_pattern_pkg::ADDR_USER1_LOW: begin
          user_word1_low_r <= reg_wdata;
        end
        test_pattern_pkg::ADDR_USER1_HIGH: begin
          user_word1_high_r <= reg_wdata;
        end
        test_pattern_pkg::ADDR_USER2_LOW: begin
          user_word2_low_r <= reg_wdata;
        end
        test_pattern_pkg::ADDR_USER2_HIGH: begin
          user_word2_high_r <= reg_wdata;
        end
        default: begin
          // Unmapped addresses are ignored
        end
      endcase
    end
  end

  // Register read-back, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        test_pattern_pkg::ADDR_TEST_CTRL: begin
          reg_rdata_r <= test_pattern_control_r;
        end
        test_pattern_pkg::ADDR_USER1_LOW: begin
          reg_rdata_r <= user_word1_low_r;
        end
        test_pattern_pkg::ADDR_USER1_HIGH: begin
          reg_rdata_r <= user_word1_high_r;
        end
        test_pattern_pkg::ADDR_USER2_LOW: begin
          reg_rdata_r <= user_word2_low_r;
        end
        test_pattern_pkg::ADDR_USER2_HIGH: begin
          reg_rdata_r <= user_word2_high_r;
        end
        default: begin
          reg_rdata_r <= 8'h00;
        end
      endcase
    end
  end
  // Read data holds until the next read strobe
  assign reg_rdata = reg_rdata_r;

  // Pattern table: word pair and whether a second word exists
  always_comb begin
    word1 = test_pattern_pkg::WORD_ZEROS;
    word2 = test_pattern_pkg::WORD_ZEROS;
    has_word2 = 1'b0;
    patt_on = 1'b1;
    case (patt_code)
      test_pattern_pkg::PATT_OFF: begin
        patt_on = 1'b0;
      end
      test_pattern_pkg::PATT_MIDSCALE: begin
        word1 = test_pattern_pkg::WORD_MIDSCALE;
      end
      test_pattern_pkg::PATT_POS_FULL: begin
        word1 = test_pattern_pkg::WORD_ONES;
      end
      test_pattern_pkg::PATT_NEG_FULL: begin
        word1 = test_pattern_pkg::WORD_ZEROS;
      end
      test_pattern_pkg::PATT_CHECKER: begin
        word1 = test_pattern_pkg::WORD_CHECK_A;
        word2 = test_pattern_pkg::WORD_CHECK_B;
        has_word2 = 1'b1;
      end
      test_pattern_pkg::PATT_ONE_ZERO: begin
        word1 = test_pattern_pkg::WORD_ONES;
        word2 = test_pattern_pkg::WORD_ZEROS;
        has_word2 = 1'b1;
      end
      test_pattern_pkg::PATT_USER: begin
        word1 = first_user_word;
        word2 = second_user_word;
        has_word2 = 1'b1;
      end
      default: begin
        patt_on = 1'b0; // Reserved codes carry no pattern
      end
    endcase
  end

  // Phase only runs while a live pattern is in alternate mode
  assign alt_mode = patt_on &&
    (test_mode == test_pattern_pkg::MODE_ALTERNATE);

  // Output phase toggles on each word accepted in alternate mode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= 1'b0;
    end else if (!alt_mode) begin
      phase_r <= 1'b0;
    end else if (gen_valid && gen_s.ready) begin
      phase_r <= !phase_r;
    end
  end

  // Word choice: static holds word 1, alternate swaps by phase
  always_comb begin
    sel_word = word1;
    if (test_mode == test_pattern_pkg::MODE_ALTERNATE && phase_r) begin
      sel_word = has_word2 ? word2 : word1;
    end
  end

  // Patterns pace at the sample rate; off passes samples through
  assign gen_valid = sample_valid;
  assign gen_data = patt_on ? sel_word[15 -: WIDTH] : sample_data;
  assign gen_s.valid = gen_valid;
  assign gen_s.data = gen_data;
  assign sample_ready = gen_s.ready;
  assign pattern_active = patt_on;

  // Output buffer lets the capture side stall the stream
  sample_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(test_pattern_pkg::FIFO_DEPTH)
  ) out_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_s(gen_s),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );
endmodule // output_test_pattern_generator

// *** verification/otpg_checker.sv ***
// Purpose: Port-level checks for the output test pattern generator.
// Assumes: Sees only the top module's ports.
// Notes: Shadows the control byte to know which word is due.
`timescale 1ns/100ps
module otpg_checker #(parameter int WIDTH = 12) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [WIDTH-1:0] sample_data,
  input wire logic sample_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [WIDTH-1:0] out_data,
  input wire logic pattern_active
);
  localparam logic [15:0] MID = test_pattern_pkg::WORD_MIDSCALE;
  logic [7:0] ctrl_r;
  logic wc;
  logic take;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Control writes and first word into an empty buffer
  assign wc = reg_wr && reg_addr == 8'hc0;
  assign take = sample_valid && sample_ready && !out_valid;
  // Shadow of the control byte
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) ctrl_r <= 8'h00;
    else if (wc) ctrl_r <= reg_wdata;
  end
  a_code_live: assert property (wc &&
    reg_wdata[3:0] inside {1, 2, 3, 4, 7, 8} |=> pattern_active)
    else $error("live code not active");
  a_code_off: assert property (wc &&
    reg_wdata[3:0] inside {0, 5, 6, [9:15]} |=> !pattern_active)
    else $error("off code active");
  a_ctrl_readback: assert property (reg_rd && !reg_wr &&
    reg_addr == 8'hc0 |=> reg_rdata == $past(ctrl_r))
    else $error("ctrl readback");
  a_unmapped_zero: assert property (reg_rd && !(reg_addr inside
    {8'hc0, [8'hc2:8'hc5]}) |=> reg_rdata == 8'h00) else $error("unmapped");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_out_hold: assert property (out_valid && !out_ready
    |=> out_valid && $stable(out_data)) else $error("head word moved");
  a_mid_word: assert property (take && ctrl_r == 8'h01
    |=> out_valid && out_data == MID[15 -: WIDTH])
    else $error("midscale word");
  a_pass_thru: assert property (take && ctrl_r[3:0] == 4'h0
    |=> out_data == $past(sample_data))
    else $error("pass through");
  a_empty_ready: assert property (!out_valid |-> sample_ready)
    else $error("empty buffer refused");
endmodule // otpg_checker

// *** verification/capture_model.sv ***
// Purpose: Capture-side model that pops the output buffer.
// Assumes: Ready moves just after the rising edge.
// Notes: Hold stalls it; coin picks ready when free.
`timescale 1ns/100ps
module capture_model (
  input wire logic core_clk,
  input wire logic hold,
  input wire logic coin,
  output logic out_ready
);
  initial out_ready = 1'b0;
  // Takes any word, leading ordinary samples included
  always @(posedge core_clk) out_ready <= #1 !hold && coin;
endmodule // capture_model

// *** verification/output_test_pattern_generator_tb_top.sv ***
// Purpose: Self-checking bench for the output test pattern generator.
// Assumes: Capture model pops the buffer at random.
// Notes: Expected words come from a table of pattern codes.
`timescale 1ns/100ps
module output_test_pattern_generator_tb_top;
  localparam int W = 12;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic sample_valid = 1'b0;
  logic [W-1:0] sample_data = '0;
  logic hold = 1'b1;
  logic coin = 1'b0;
  logic [7:0] reg_rdata;
  logic sample_ready, out_valid, out_ready, pattern_active;
  logic [W-1:0] out_data;
  logic [15:0] user_w1, user_w2;
  logic [W-1:0] exp_q[$];
  integer seed = 81;
  integer miscompares = 0;
  integer checked = 0;
  integer cycles = 0;
  always #20 core_clk = ~core_clk;
  output_test_pattern_generator #(.WIDTH(W)) dut (.core_clk(core_clk),
    .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .sample_ready(sample_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data),
    .pattern_active(pattern_active));
  capture_model partner (.core_clk(core_clk), .hold(hold), .coin(coin),
    .out_ready(out_ready));
  task automatic close_out();
    $display("Checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register read data
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp(16'(got), 16'(exp));
  endtask
  // Words popped from the output bus
  task automatic cmp_word(input logic [W-1:0] got, input logic [W-1:0] exp);
    cmp(16'(got), 16'(exp));
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk) #1 reg_wr = 1'b0;
    @(posedge core_clk) #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk) #1 reg_rd = 1'b0;
    cmp_reg(reg_rdata, e);
    @(posedge core_clk) #1;
  endtask
  // Word due for the k-th accepted sample under control byte c
  function automatic logic [W-1:0] due(input logic [7:0] c, input int k,
      input logic [W-1:0] s);
    logic [31:0] w;
    case (c[3:0])
      4'h1: w = {16'h8000, 16'h8000};
      4'h2: w = {16'hffff, 16'hffff};
      4'h3: w = {16'h0000, 16'h0000};
      4'h4: w = {16'haaaa, 16'h5555};
      4'h7: w = {16'hffff, 16'h0000};
      4'h8: w = {user_w1, user_w2};
      default: return s;
    endcase
    if (c[7:6] == 2'h1 && k % 2 == 1) return w[15 -: W];
    return w[31 -: W];
  endfunction
  // Offer one sample, hold it until taken, queue the word due
  task automatic send(input logic [7:0] c, input int k);
    logic ok;
    sample_valid = 1'b1;
    sample_data = W'($random(seed));
    for (int n = 0; n < 200; n++) begin
      ok = sample_ready;
      @(posedge core_clk) #1;
      if (ok) break;
    end
    exp_q.push_back(due(c, k, sample_data));
  endtask
  // Cycle ceiling and random ready
  always @(posedge core_clk) begin
    cycles++;
    coin <= #1 1'($random(seed));
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  // Score each popped word
  always @(posedge core_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1)
      cmp_word(out_data, exp_q.pop_front());
  end
  initial begin
    logic [7:0] c;
    repeat (8) @(posedge core_clk);
    #1 nrst = 1'b1;
    for (int a = 8'hc0; a < 8'hc6; a++) rd(8'(a), 8'h00);
    user_w1 = 16'($random(seed));
    user_w2 = 16'($random(seed));
    wr(8'hc2, user_w1[7:0]);
    wr(8'hc3, user_w1[15:8]);
    wr(8'hc4, user_w2[7:0]);
    wr(8'hc5, user_w2[15:8]);
    rd(8'hc3, user_w1[15:8]);
    rd(8'hc5, user_w2[15:8]);
    rd(8'hc2, user_w1[7:0]);
    rd(8'hc4, user_w2[7:0]);
    wr(8'hc0, 8'h48);
    for (int k = 0; k < 16; k++) send(8'h48, k);
    cmp(16'(sample_ready), 16'h0000);
    hold = 1'b0;
    for (int k = 16; k < 20; k++) send(8'h48, k);
    for (int i = 0; i < 64; i++) begin
      c = {i[5:4], 2'b00, i[3:0]};
      sample_valid = 1'b0;
      for (int n = 0; n < 300 && exp_q.size() > 0; n++) begin
        @(posedge core_clk) #1;
      end
      wr(8'hc0, 8'h00);
      wr(8'hc0, c);
      rd(8'hc0, c);
      cmp(16'(pattern_active), 16'(c[3:0] inside {1, 2, 3, 4, 7, 8}));
      for (int k = 0; k < 6; k++) send(c, k);
    end
    sample_valid = 1'b0;
    rd(8'h01, 8'h00);
    repeat (60) @(posedge core_clk);
    cmp(16'(exp_q.size()), 16'h0000);
    close_out();
  end
endmodule // output_test_pattern_generator_tb_top
bind output_test_pattern_generator otpg_checker #(.WIDTH(WIDTH)) chk (
  .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .sample_valid(sample_valid), .sample_data(sample_data),
  .sample_ready(sample_ready), .out_valid(out_valid), .out_ready(out_ready),
  .out_data(out_data), .pattern_active(pattern_active));
